// ==== hw/mcsr_regs.svh ====
// register offsets, field positions, reset values and timing counts for the mac control block
`ifndef MCSR_REGS_SVH
`define MCSR_REGS_SVH
`define MCSR_OFF_NET_CTRL 8'h00
`define MCSR_OFF_NET_STAT 8'h01
`define MCSR_OFF_TX_CTRL 8'h02
`define MCSR_OFF_TX_STAT1 8'h03
`define MCSR_OFF_TX_STAT2 8'h04
`define MCSR_OFF_RES_CLK 8'h51
`define MCSR_OFF_MRD_NOINC 8'hf0
`define MCSR_OFF_MRD_INC_ALT 8'hf1
`define MCSR_OFF_MRD_INC 8'hf2
`define MCSR_OFF_MRA_LO 8'hf4
`define MCSR_OFF_MRA_HI 8'hf5
`define MCSR_OFF_MWR_NOINC 8'hf6
`define MCSR_OFF_MWR_INC 8'hf8
`define MCSR_OFF_MWA_LO 8'hfa
`define MCSR_OFF_MWA_HI 8'hfb
`define MCSR_OFF_TXLEN_LO 8'hfc
`define MCSR_OFF_TXLEN_HI 8'hfd
`define MCSR_OFF_INT_STAT 8'hfe
`define MCSR_OFF_INT_MASK 8'hff
// network control fields
`define MCSR_NC_SWRST 0
`define MCSR_NC_FDX 3
`define MCSR_NC_FORCE_COLLISION 4
`define MCSR_NC_WAKEUP_ENABLE 6
// network status fields
`define MCSR_NS_RX_FIFO_OVERFLOW_FLAG 1
`define MCSR_NS_TX1 2
`define MCSR_NS_TX2 3
`define MCSR_NS_WAKE 5
`define MCSR_NS_LINK 6
`define MCSR_NS_SPEED 7
// transmit control fields
`define MCSR_TC_REQ 0
`define MCSR_TC_FCS1 1
`define MCSR_TC_PAD1 2
`define MCSR_TC_FCS2 3
`define MCSR_TC_PAD2 4
`define MCSR_TC_EXCM 5
`define MCSR_TC_JDIS 6
`define MCSR_RST_VAL 8'h00
// software reset auto-clear time
`define MCSR_SWRST_NS 10000
`define MCSR_CLK_NS 5
`define MCSR_SWRST_CYC (`MCSR_SWRST_NS / `MCSR_CLK_NS)
`define MCSR_JABBER_BYTES 2048
`define MCSR_COL_WINDOW_BYTES 64
`define MCSR_COL_ABORT 16
`endif

// ==== hw/mcsr_pkg.sv ====
// types shared by the mac control and status block
package mcsr_pkg;
  typedef enum logic [1:0] {
    MCSR_LB_NORMAL,
    MCSR_LB_MAC,
    MCSR_LB_PHY100,
    MCSR_LB_RSVD
  } mcsr_loop_t;

  // per-frame transmit result reported by the transmit engine
  typedef struct packed {
    logic jabber_timeout;
    logic carrier_loss;
    logic no_carrier;
    logic late_collision;
    logic collision;
    logic excess_collision;
  } mcsr_txres_t;

  // controls handed to the transmit engine
  typedef struct packed {
    logic jabber_timer_disable;
    logic excess_collision_policy;
    logic pad_off_index2;
    logic fcs_off_index2;
    logic pad_off_index1;
    logic fcs_off_index1;
    logic transmit_request;
    logic force_collision;
    mcsr_loop_t loopback_select;
    logic wakeup_enable;
  } mcsr_ctrl_t;

  // sram access strobes toward the packet memory
  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] rd_addr;
    logic [15:0] wr_addr;
    logic [7:0] wr_data;
  } mcsr_mem_t;

  typedef struct packed {
    logic [7:0] net_ctrl;
    logic wake_flag;
    logic tx1_done;
    logic tx2_done;
    logic [7:0] tx_ctrl;
    logic [5:0] tx_stat1;
    logic [5:0] tx_stat2;
    logic [7:0] res_clk;
    logic [15:0] rd_addr;
    logic [15:0] wr_addr;
    logic [15:0] tx_len;
    logic [7:0] int_stat;
    logic [7:0] int_mask;
    logic [7:0] rd_data;
    logic [7:0] prefetch;
    logic [15:0] swrst_cnt;
    logic swrst_busy;
    logic next_index2;
    logic mem_rd;
    logic mem_wr;
    logic [7:0] mem_wdata;
    logic [15:0] mem_waddr;
    logic [15:0] mem_raddr;
  } mcsr_state_t;
endpackage : mcsr_pkg

// ==== hw/mcsr_core.sv ====
// control and status registers of the 10/100 mac
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "mcsr_regs.svh"
// Functional notes
// - software reset bit self-clears after 10us
// - wakeup enable; clearing it clears wake flags
// - loopback field selects normal, mac, phy
// - force collision bit forces transmit collisions
// - read-only full-duplex bit from phy
// - speed bit reads 0=100M, 1=10M
// - link bit reads 1 when link up
// - wake flag clears on read or write-one
// - per-index done flags, clear on read/write-one
// - jabber disable turns off 2048-byte timer
// - collision policy: abort after 16 or retry
// - pad disable bits per packet index
// - crc disable bits per packet index
// - transmit request self-clears when sent
// - status flags jabber timeout truncation
// - status flags carrier loss and no carrier
// - status flags late collision after 64 bytes
// - status flags any collision in frame
// - status flags abort after 16 collisions
// - reserved bits written zero, read zero here
// - f0 prefetch read, f2 read with increment
// - f6 write, f8 write with increment
// - srst restores all defaults; soft reset keeps wakeup enable, wake flag, length, res_clk
module mcsr_core
  import mcsr_pkg::*;
#(
  parameter int SWRST_CYCLES = `MCSR_SWRST_CYC
)(
  input wire logic mclk,
  input wire logic srst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic phy_full_duplex,
  input wire logic phy_speed_10,
  input wire logic phy_link_up,
  input wire logic wake_event,
  input wire logic rx_fifo_overflow,
  input wire logic tx_done,
  input wire logic tx_done_index2,
  input wire mcsr_txres_t tx_result,
  input wire logic [7:0] mem_rdata,
  output mcsr_ctrl_t ctrl,
  output logic [15:0] tx_length,
  output logic soft_reset,
  output mcsr_mem_t mem
);
  mcsr_state_t s;
  mcsr_state_t next_s;
  logic [2:0] sync_fdx;
  logic [2:0] sync_spd;
  logic [2:0] sync_lnk;
  logic [2:0] sync_wake;
  logic [2:0] sync_ov;
  logic fdx_q;
  logic spd_q;
  logic lnk_q;
  logic ov_q;
  logic wake_q;
  logic wake_seen;
  logic sw;

  // pins pass three stages; level taken once stages two and three agree
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      sync_fdx <= 3'h0;
      sync_spd <= 3'h0;
      sync_lnk <= 3'h0;
      sync_wake <= 3'h0;
      sync_ov <= 3'h0;
      fdx_q <= 1'b0;
      spd_q <= 1'b0;
      lnk_q <= 1'b0;
      ov_q <= 1'b0;
      wake_q <= 1'b0;
    end
    else
    begin
      sync_fdx <= {sync_fdx[1:0], phy_full_duplex};
      sync_spd <= {sync_spd[1:0], phy_speed_10};
      sync_lnk <= {sync_lnk[1:0], phy_link_up};
      sync_wake <= {sync_wake[1:0], wake_event};
      sync_ov <= {sync_ov[1:0], rx_fifo_overflow};
      if (sync_fdx[1] == sync_fdx[2]) fdx_q <= sync_fdx[2];
      if (sync_spd[1] == sync_spd[2]) spd_q <= sync_spd[2];
      if (sync_lnk[1] == sync_lnk[2]) lnk_q <= sync_lnk[2];
      if (sync_ov[1] == sync_ov[2]) ov_q <= sync_ov[2];
      if (sync_wake[1] == sync_wake[2]) wake_q <= sync_wake[2];
    end
  end

  // rising edge of the filtered wake level
  assign wake_seen = sync_wake[1] & sync_wake[2] & ~wake_q;
  // self-clearing software reset acts like srst on most state
  assign sw = s.swrst_busy;

  always_comb
  begin
    next_s = s;
    next_s.mem_rd = 1'b0;
    next_s.mem_wr = 1'b0;
    next_s.rd_data = 8'h00;
    // software reset counts up then clears its bit
    if (s.swrst_busy)
    begin
      if (s.swrst_cnt == 16'(SWRST_CYCLES - 1))
      begin
        next_s.swrst_busy = 1'b0;
        next_s.swrst_cnt = 16'h0000;
        next_s.net_ctrl[`MCSR_NC_SWRST] = 1'b0;
      end
      else
        next_s.swrst_cnt = s.swrst_cnt + 16'h0001;
      // defaults except wakeup enable, wake flag, tx_len and res_clk
      next_s.net_ctrl = {1'b0, s.net_ctrl[`MCSR_NC_WAKEUP_ENABLE], 6'h00} |
        {7'h00, next_s.net_ctrl[`MCSR_NC_SWRST]};
      next_s.tx1_done = 1'b0;
      next_s.tx2_done = 1'b0;
      next_s.tx_ctrl = `MCSR_RST_VAL;
      next_s.tx_stat1 = 6'h00;
      next_s.tx_stat2 = 6'h00;
      next_s.rd_addr = 16'h0000;
      next_s.wr_addr = 16'h0000;
      next_s.int_stat = `MCSR_RST_VAL;
      next_s.int_mask = `MCSR_RST_VAL;
      next_s.next_index2 = 1'b0;
    end
    // register reads; wake and done flags clear on read
    if (rd)
    begin
      case (addr)
        `MCSR_OFF_NET_CTRL: next_s.rd_data = {1'b0, s.net_ctrl[6], 1'b0, s.net_ctrl[4],
          fdx_q, s.net_ctrl[2:1], s.net_ctrl[0]};
        `MCSR_OFF_NET_STAT:
        begin
          next_s.rd_data = {spd_q, lnk_q, s.wake_flag, 1'b0, s.tx2_done, s.tx1_done,
            ov_q, 1'b0};
          next_s.wake_flag = 1'b0;
          next_s.tx1_done = 1'b0;
          next_s.tx2_done = 1'b0;
        end
        `MCSR_OFF_TX_CTRL: next_s.rd_data = {1'b0, s.tx_ctrl[6:0]};
        `MCSR_OFF_TX_STAT1: next_s.rd_data = {s.tx_stat1, 2'b00};
        `MCSR_OFF_TX_STAT2: next_s.rd_data = {s.tx_stat2, 2'b00};
        `MCSR_OFF_RES_CLK: next_s.rd_data = s.res_clk;
        `MCSR_OFF_MRD_NOINC:
        begin
          next_s.rd_data = mem_rdata; // prefetch, address held
          next_s.prefetch = mem_rdata;
        end
        `MCSR_OFF_MRD_INC, `MCSR_OFF_MRD_INC_ALT:
        begin
          next_s.rd_data = mem_rdata;
          next_s.mem_rd = 1'b1;
          next_s.rd_addr = s.rd_addr + 16'h0001;
        end
        `MCSR_OFF_MRA_LO: next_s.rd_data = s.rd_addr[7:0];
        `MCSR_OFF_MRA_HI: next_s.rd_data = s.rd_addr[15:8];
        `MCSR_OFF_MWA_LO: next_s.rd_data = s.wr_addr[7:0];
        `MCSR_OFF_MWA_HI: next_s.rd_data = s.wr_addr[15:8];
        `MCSR_OFF_TXLEN_LO: next_s.rd_data = s.tx_len[7:0];
        `MCSR_OFF_TXLEN_HI: next_s.rd_data = s.tx_len[15:8];
        `MCSR_OFF_INT_STAT: next_s.rd_data = s.int_stat;
        `MCSR_OFF_INT_MASK: next_s.rd_data = s.int_mask;
        default: next_s.rd_data = 8'h00; // unmapped reads as zero
      endcase
    end
    // register writes; reserved bits are dropped
    // writes during a running software reset are ignored so defaults hold throughout
    if (wr && !s.swrst_busy)
    begin
      case (addr)
        `MCSR_OFF_NET_CTRL:
        begin
          next_s.net_ctrl[`MCSR_NC_WAKEUP_ENABLE] = wdata[6];
          next_s.net_ctrl[`MCSR_NC_FORCE_COLLISION] = wdata[4];
          next_s.net_ctrl[2:1] = wdata[2:1];
          if (wdata[`MCSR_NC_SWRST] && !s.swrst_busy)
          begin
            next_s.net_ctrl[`MCSR_NC_SWRST] = 1'b1;
            next_s.swrst_busy = 1'b1;
            next_s.swrst_cnt = 16'h0000;
          end
          if (!wdata[6]) next_s.wake_flag = 1'b0;
        end
        `MCSR_OFF_NET_STAT:
        begin
          if (wdata[`MCSR_NS_WAKE]) next_s.wake_flag = 1'b0;
          if (wdata[`MCSR_NS_TX2]) next_s.tx2_done = 1'b0;
          if (wdata[`MCSR_NS_TX1]) next_s.tx1_done = 1'b0;
        end
        `MCSR_OFF_TX_CTRL:
          next_s.tx_ctrl = {1'b0, wdata[6:1], wdata[0] | s.tx_ctrl[0]};
        `MCSR_OFF_RES_CLK: next_s.res_clk = wdata;
        `MCSR_OFF_MWR_NOINC:
        begin
          next_s.mem_wr = 1'b1;
          next_s.mem_wdata = wdata;
          next_s.mem_waddr = s.wr_addr;
        end
        `MCSR_OFF_MWR_INC:
        begin
          next_s.mem_wr = 1'b1;
          next_s.mem_wdata = wdata;
          next_s.mem_waddr = s.wr_addr;
          next_s.wr_addr = s.wr_addr + 16'h0001;
        end
        `MCSR_OFF_MRA_LO: next_s.rd_addr[7:0] = wdata;
        `MCSR_OFF_MRA_HI: next_s.rd_addr[15:8] = wdata;
        `MCSR_OFF_MWA_LO: next_s.wr_addr[7:0] = wdata;
        `MCSR_OFF_MWA_HI: next_s.wr_addr[15:8] = wdata;
        `MCSR_OFF_TXLEN_LO: next_s.tx_len[7:0] = wdata;
        `MCSR_OFF_TXLEN_HI: next_s.tx_len[15:8] = wdata;
        `MCSR_OFF_INT_STAT: next_s.int_stat = s.int_stat & ~wdata;
        `MCSR_OFF_INT_MASK: next_s.int_mask = wdata;
        default: next_s.res_clk = next_s.res_clk; // unmapped writes ignored
      endcase
    end
    next_s.mem_raddr = next_s.rd_addr;
    // hardware events last so a set beats a same-cycle clear
    if (wake_seen && s.net_ctrl[`MCSR_NC_WAKEUP_ENABLE]) next_s.wake_flag = 1'b1;
    if (tx_done && !sw)
    begin
      // done flag, status and request clear
      if (tx_done_index2)
      begin
        next_s.tx2_done = 1'b1;
        next_s.tx_stat2 = tx_result;
      end
      else
      begin
        next_s.tx1_done = 1'b1;
        next_s.tx_stat1 = tx_result;
      end
      // a request written in the completing cycle is a new packet and survives
      next_s.tx_ctrl[`MCSR_TC_REQ] = wr && !s.swrst_busy && addr == `MCSR_OFF_TX_CTRL &&
        wdata[`MCSR_TC_REQ];
    end
  end

  // one register stage for all state
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      s <= '0;
      s.mem_raddr <= 16'h0000;
    end
    else
      s <= next_s;
  end

  // outputs toward the transmit engine and packet memory
  always_comb
  begin
    ctrl.jabber_timer_disable = s.tx_ctrl[`MCSR_TC_JDIS];
    ctrl.excess_collision_policy = s.tx_ctrl[`MCSR_TC_EXCM];
    ctrl.pad_off_index2 = s.tx_ctrl[`MCSR_TC_PAD2];
    ctrl.fcs_off_index2 = s.tx_ctrl[`MCSR_TC_FCS2];
    ctrl.pad_off_index1 = s.tx_ctrl[`MCSR_TC_PAD1];
    ctrl.fcs_off_index1 = s.tx_ctrl[`MCSR_TC_FCS1];
    ctrl.transmit_request = s.tx_ctrl[`MCSR_TC_REQ];
    ctrl.force_collision = s.net_ctrl[`MCSR_NC_FORCE_COLLISION];
    ctrl.loopback_select = mcsr_loop_t'(s.net_ctrl[2:1]);
    ctrl.wakeup_enable = s.net_ctrl[`MCSR_NC_WAKEUP_ENABLE];
    mem.rd = s.mem_rd;
    mem.wr = s.mem_wr;
    mem.rd_addr = s.mem_raddr;
    mem.wr_addr = s.mem_waddr;
    mem.wr_data = s.mem_wdata;
  end

  assign rdata = s.rd_data;
  assign tx_length = s.tx_len;
  assign soft_reset = s.swrst_busy;
endmodule : mcsr_core
`default_nettype wire

// ==== testbench/mcsr_core_asserts.sv ====
// checker for the mac control and status registers
`timescale 1ns/1ps
`default_nettype none
module mcsr_core_asserts
  import mcsr_pkg::*;
#(
  parameter int SWRST_CYCLES = 2000
)(
  input wire logic mclk,
  input wire logic srst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic tx_done,
  input wire mcsr_ctrl_t ctrl,
  input wire logic soft_reset,
  input wire mcsr_mem_t mem
);
  logic [15:0] hi_cnt;
  // length of the running soft reset pulse
  always_ff @(posedge mclk)
    hi_cnt <= (srst || !soft_reset) ? 16'h0000 : hi_cnt + 16'h0001;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  sequence s_stat_read;
    rd && addr == 8'h01 && !tx_done;
  endsequence
  sequence s_mem_write;
    wr && (addr == 8'hf6 || addr == 8'hf8) && !soft_reset;
  endsequence
  a_swrst_start: assert property (
    wr && addr == 8'h00 && wdata[0] && !soft_reset |=> soft_reset) else $error("no soft reset");
  a_swrst_len: assert property (
    $fell(soft_reset) |-> hi_cnt == SWRST_CYCLES) else $error("soft reset length");
  a_swrst_hold: assert property (
    soft_reset && $past(soft_reset) |-> ctrl.loopback_select == 2'b00 && !ctrl.force_collision
    && !ctrl.transmit_request) else $error("control not held at default");
  a_transmit_request_set: assert property (
    wr && addr == 8'h02 && wdata[0] && !soft_reset |=> ctrl.transmit_request)
    else $error("request not raised");
  a_tx_ctrl: assert property (
    wr && addr == 8'h02 && !soft_reset |=> {ctrl.jabber_timer_disable,
    ctrl.excess_collision_policy, ctrl.pad_off_index2, ctrl.fcs_off_index2, ctrl.pad_off_index1,
    ctrl.fcs_off_index1} == $past(wdata[6:1])) else $error("tx control mismatch");
  a_net_ctrl: assert property (
    wr && addr == 8'h00 && !wdata[0] && !soft_reset |=> ctrl.force_collision == $past(wdata[4])
    && ctrl.loopback_select == $past(wdata[2:1]) && ctrl.wakeup_enable == $past(wdata[6]))
    else $error("net control mismatch");
  a_mem_read: assert property (
    rd && (addr == 8'hf1 || addr == 8'hf2) |=> mem.rd) else $error("memory read strobe lost");
  a_prefetch_hold: assert property (
    rd && addr == 8'hf0 |=> !mem.rd && $stable(mem.rd_addr)) else $error("prefetch moved address");
  a_mem_write: assert property (
    s_mem_write |=> mem.wr && mem.wr_data == $past(wdata)) else $error("memory write lost");
  a_done_clear: assert property (
    s_stat_read ##1 (rd && addr == 8'h01) |=> rdata[3:2] == 2'b00) else $error("done not cleared");
endmodule : mcsr_core_asserts
bind mcsr_core mcsr_core_asserts #(.SWRST_CYCLES(SWRST_CYCLES)) u_chk (.mclk, .srst, .addr,
  .wdata, .wr, .rd, .rdata, .tx_done, .ctrl, .soft_reset, .mem);
`default_nettype wire

// ==== testbench/mcsr_tx_model.sv ====
// transmit engine stand-in: answers each transmit request with one done pulse
`timescale 1ns/1ps
`default_nettype none
module mcsr_tx_model
  import mcsr_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire mcsr_ctrl_t ctrl,
  input wire logic index2,
  input wire mcsr_txres_t result,
  input wire logic [7:0] delay,
  output logic tx_done,
  output logic tx_done_index2,
  output mcsr_txres_t tx_result
);
  logic [7:0] cnt = 8'h00;
  // qualifiers mean nothing beside an idle pulse, so show junk then
  assign tx_done_index2 = tx_done ? index2 : ~index2;
  assign tx_result = tx_done ? result : ~result;
  // frame time counts down; no restart in the cycle its done pulse is high
  always @(posedge mclk)
  begin
    tx_done <= 1'b0;
    if (srst)
      cnt <= 8'h00;
    else if (cnt == 8'h00 && ctrl.transmit_request && !tx_done)
      cnt <= delay;
    else if (cnt != 8'h00)
    begin
      cnt <= cnt - 8'h01;
      tx_done <= (cnt == 8'h01);
    end
  end
endmodule : mcsr_tx_model
`default_nettype wire

// ==== testbench/tb.sv ====
// self-checking bench for the mac control and status registers
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin fails++; \
  $display("unexpected at %0t: %h not %h", $time, g, e); end end
module tb
  import mcsr_pkg::*;
;
  logic mclk = 0, srst = 1, wr = 0, rd = 0, pend = 0, tx_index2 = 0;
  logic phy_full_duplex = 0, phy_speed_10 = 0, phy_link_up = 0, wake_event = 0;
  logic rx_fifo_overflow = 0, tx_done, tx_done_index2, soft_reset;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, d, mem_rdata;
  logic [15:0] tx_length, rexp;
  logic [23:0] wexp;
  logic [15:0] rq[$];
  logic [23:0] wq[$];
  logic [7:0] regs[12] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'hf4, 8'hf5, 8'hfa, 8'hfb,
    8'hfe, 8'hff, 8'h80};
  mcsr_txres_t tx_result, tx_res = '0;
  mcsr_ctrl_t ctrl;
  mcsr_mem_t mem;
  int fails = 0, check_count = 0, n;
  assign mem_rdata = mem.rd_addr[7:0] ^ mem.rd_addr[15:8] ^ 8'h5a; // packet memory stand-in
  mcsr_core #(.SWRST_CYCLES(20)) u_mcsr_core (.mclk, .srst, .addr, .wdata, .wr, .rd, .rdata,
    .phy_full_duplex, .phy_speed_10, .phy_link_up, .wake_event, .rx_fifo_overflow, .tx_done,
    .tx_done_index2, .tx_result, .mem_rdata, .ctrl, .tx_length, .soft_reset, .mem);
  mcsr_tx_model u_mcsr_tx_model (.mclk, .srst, .ctrl, .index2(tx_index2), .result(tx_res),
    .delay(8'h05), .tx_done, .tx_done_index2, .tx_result);
  // 200 MHz clock
  initial
  begin
    forever #2.5 mclk = ~mclk;
  end
  // one bus cycle; the strobe stays up so calls run back to back
  task automatic put(input logic w, input logic [7:0] a, input logic [7:0] v);
    @(posedge mclk);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= v;
  endtask : put
  task automatic get(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m = 8'hff);
    put(1'b0, a, 8'h00);
    rq.push_back({e, m});
  endtask : get
  task automatic idle(input int c);
    @(posedge mclk);
    wr <= 1'b0;
    rd <= 1'b0;
    repeat (c) @(posedge mclk);
  endtask : idle
  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : test_done
  // read data lands one cycle after its strobe; memory writes in order
  always @(negedge mclk)
  begin
    if (pend)
    begin
      rexp = rq.pop_front();
      `CHK(rdata & rexp[7:0], rexp[15:8] & rexp[7:0])
    end
    pend = rd;
    if (mem.wr === 1'b1)
    begin
      wexp = wq.pop_front();
      `CHK({mem.wr_addr, mem.wr_data}, wexp)
    end
  end
  initial
  begin
    void'($urandom(79249));
    repeat (3) @(posedge mclk);
    srst <= 1'b0;
    foreach (regs[i]) get(regs[i], 8'h00);
    repeat (4)
    begin
      d = 8'($urandom()) & 8'hfe;
      put(1'b1, 8'h02, d);
      get(8'h02, d & 8'h7e);
    end
    // loop modes with reserved bit 5 and read-only bit 3 written high; reserved bit 7 only in modes 1 and 3
    for (int i = 0; i < 4; i++)
    begin
      d = {i[0], i[1], 1'b1, i[0], 1'b1, i[1:0], 1'b0};
      put(1'b1, 8'h00, d);
      get(8'h00, d & 8'h56);
    end
    put(1'b1, 8'h00, 8'h40);
    phy_full_duplex <= 1'b1;
    phy_speed_10 <= 1'b1;
    phy_link_up <= 1'b1;
    rx_fifo_overflow <= 1'b1;
    wake_event <= 1'b1;
    idle(10);
    get(8'h00, 8'h48);
    get(8'h01, 8'he2);
    get(8'h01, 8'hc2);
    // clear by write of one, then by dropping the wakeup enable
    for (int k = 0; k < 2; k++)
    begin
      wake_event <= 1'b0;
      idle(5);
      wake_event <= 1'b1;
      idle(10);
      put(1'b1, k ? 8'h00 : 8'h01, k ? 8'h00 : 8'h20);
      get(8'h01, 8'hc2);
    end
    for (int k = 0; k < 2; k++)
    begin
      tx_index2 <= k[0];
      tx_res <= 6'($urandom());
      put(1'b1, 8'h02, 8'h01);
      idle(1);
      for (n = 0; n < 100 && ctrl.transmit_request !== 1'b0; n++) @(negedge mclk);
      if (n == 100)
      begin
        fails++;
        test_done();
      end
      get(8'h01, 8'hc2 | (8'h04 << k));
      get(8'h01, 8'hc2);
      get(8'h03 + 8'(k), {tx_res, 2'b00});
    end
    put(1'b1, 8'hfa, 8'h10);
    put(1'b1, 8'hfb, 8'h00);
    for (int k = 0; k < 4; k++)
    begin
      d = 8'($urandom());
      wq.push_back({16'h0010 + 16'(k < 2 ? k : 2), d});
      put(1'b1, k < 2 ? 8'hf8 : 8'hf6, d);
    end
    put(1'b1, 8'hf4, 8'h20);
    put(1'b1, 8'hf5, 8'h01);
    for (int k = 0; k < 5; k++)
      get(k < 2 ? 8'hf0 : (k < 4 ? 8'hf2 : 8'hf1), 8'h7b ^ 8'(k < 3 ? 0 : k - 2));
    // length and clock-resume bytes are not cleared by software reset and must survive
    d = 8'($urandom());
    put(1'b1, 8'hfc, d);
    put(1'b1, 8'hfd, ~d);
    put(1'b1, 8'h51, d ^ 8'h3c);
    put(1'b1, 8'h02, 8'h7e);
    put(1'b1, 8'h00, 8'h41);
    idle(1);
    get(8'h00, 8'h41, 8'hf7);
    idle(0);
    for (n = 0; n < 100 && soft_reset !== 1'b0; n++) @(negedge mclk);
    if (n == 100)
    begin
      fails++;
      test_done();
    end
    get(8'h02, 8'h00);
    get(8'h00, 8'h40, 8'hf7);
    get(8'hf4, 8'h00);
    get(8'hfa, 8'h00);
    get(8'hfc, d);
    get(8'hfd, ~d);
    get(8'h51, d ^ 8'h3c);
    `CHK(tx_length, {~d, d})
    idle(3);
    test_done();
  end
endmodule : tb
`default_nettype wire
